// ---- hw/set_features_and_max_address.sv ----
// What this block does
// - Zero transfer value selects default PIO
// - Accept every PIO mode up to maximum
// - Drive IORDY whenever PIO mode is three+
// - No Multiword DMA in card-bus modes
// - Accept all Multiword DMA modes up to top
// - Accept all Ultra DMA modes up to top
// - Enabling one DMA family clears other
// - Decode power-management level scale correctly
// - Valid levels accepted, behaviour unchanged
// - Level 80h or above forbids standby
// - Subcommand 85h turns power management off
// - Power level 1 commands off by default
// - Look-ahead and long data default on
// - Current limit from quarter-milliamp sector count
// - Return lowest and highest current settings
// - Current limit defaults high, clamps outside range
// - Soft reset restores defaults unless disabled
// - Set max needs ready, preceding native read
// - Volatile bit decides survival over hardware resets
// - Decode set-max password, lock, unlock, freeze
// - Abort second non-volatile set after reset
// - Transfer type upper bits, mode lower
`timescale 1ns/1ps
`default_nettype none
module set_features_and_max_address
    import feat_pkg::*;
#(
    parameter logic [2:0]  PIO_MAX     = 3'h4,   // Highest PIO mode
    parameter logic [2:0]  MDMA_MAX    = 3'h2,   // Highest Multiword DMA mode
    parameter logic [2:0]  UDMA_MAX    = 3'h2,   // Highest Ultra DMA mode
    parameter logic        NO_IORDY_OK = 1'b1,   // IORDY may be disabled
    parameter logic [7:0]  CUR_MIN     = 8'h01,  // Lowest current setting
    parameter logic [7:0]  CUR_MAX     = 8'h40,  // Highest current setting
    parameter logic [27:0] NATIVE_MAX  = 28'hFFFFFFF // Native capacity
)(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       hw_reset,      // Hardware reset pulse
    input  wire logic       soft_reset,    // Soft reset pulse
    input  wire logic       dev_ready,     // Device reports ready
    input  wire logic       pc_card_mode,  // Card-bus interface active
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire cmd_t       cmd_in,
    output logic            done,
    output logic            aborted,
    output cmd_t            result,
    output xfer_cfg_t       xfer_cfg,
    output logic            apm_en,
    output logic [7:0]      apm_level,
    output logic            standby_permit,
    output logic            pl1_en,
    output logic [7:0]      cur_limit,
    output logic            por_revert,
    output logic [27:0]     max_lba,
    output logic            max_locked,
    output logic            max_frozen,
    output logic            pw_set
);

    ////////////////////////////////////////////////////////////////
    // State machine
    ////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } st_t;

    st_t        st_r;          // Current state
    st_t        st_nxt;        // Next state
    cmd_t       cmd_r;         // Latched task file

    // Settings
    xfer_cfg_t  xf_r;          // Transfer configuration
    logic       noi_r;         // IORDY disabled by request
    logic       apm_en_r;      // Power management on
    logic [7:0] apm_lvl_r;     // Power management level
    logic       pl1_r;         // Power level 1 enabled
    logic [7:0] cur_r;         // Current limit setting
    logic       revert_r;      // Soft reset restores defaults

    // Max-address state
    logic [27:0] max_r;        // Active maximum
    logic [27:0] nv_max_r;     // Last non-volatile maximum
    logic        nv_used_r;    // A non-volatile set since reset
    logic        rnm_prev_r;   // Previous command was native read
    logic        lock_r;       // Set max locked
    logic        frz_r;        // Set max frozen
    logic        pw_r;         // Password stored

    // Answer registers
    logic        done_r;
    logic        abort_r;
    cmd_t        res_r;

    ////////////////////////////////////////////////////////////////
    // Decoders
    ////////////////////////////////////////////////////////////////

    xfer_dec_t xd;             // Transfer-mode decode
    logic      apm_ok;         // Level inside the valid scale
    logic      apm_nostby;     // Level forbids standby
    logic      cur_nostby;     // Live level forbids standby

    xfer_mode_decode #(
        .PIO_MAX     (PIO_MAX),
        .MDMA_MAX    (MDMA_MAX),
        .UDMA_MAX    (UDMA_MAX),
        .NO_IORDY_OK (NO_IORDY_OK)
    ) u_xfer (
        .sect_cnt     (cmd_r.sect_cnt),
        .pc_card_mode (pc_card_mode),
        .dec          (xd)
    );

    apm_level_decode u_apm_req (
        .level      (cmd_r.sect_cnt),
        .valid      (apm_ok),
        .no_standby (apm_nostby)
    );

    apm_level_decode u_apm_cur (
        .level      (apm_lvl_r),
        .valid      (),
        .no_standby (cur_nostby)
    );

    // Clamp a requested current into the supported range
    function automatic logic [7:0] clamp_cur(input logic [7:0] v);
        if (v < CUR_MIN)
            clamp_cur = CUR_MIN;
        else if (v > CUR_MAX)
            clamp_cur = CUR_MAX;
        else
            clamp_cur = v;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Command decode
    ////////////////////////////////////////////////////////////////

    wire exec   = (st_r == ST_EXEC);
    wire is_sf  = exec && (cmd_r.command == CMD_SET_FEATURES);
    wire is_rnm = exec && (cmd_r.command == CMD_READ_NATIVE);
    wire is_sm  = exec && (cmd_r.command == CMD_SET_MAX);
    wire [7:0] ft = cmd_r.features;

    // Set Features subcommands
    wire f_xfer   = is_sf && (ft == FEAT_XFER_MODE);
    wire f_apm_on = is_sf && (ft == FEAT_APM_ON);
    wire f_apm_of = is_sf && (ft == FEAT_APM_OFF);
    wire f_pl1_on = is_sf && (ft == FEAT_PL1_ON);
    wire f_pl1_of = is_sf && (ft == FEAT_PL1_OFF);
    wire f_cur    = is_sf && (ft == FEAT_CUR_LIMIT);
    wire f_keep   = is_sf && (ft == FEAT_POR_KEEP);
    wire f_rev    = is_sf && (ft == FEAT_POR_REVERT);
    // Defaults already in force; only acknowledged
    wire f_nop    = is_sf && ((ft == FEAT_LOOKAHD_A) || (ft == FEAT_LOOKAHD_B)
                  || (ft == FEAT_LONG4) || (ft == FEAT_NOP_A)
                  || (ft == FEAT_NOP_B) || (ft == FEAT_NOP_C));

    // Failed Set Features cases
    wire sf_bad = is_sf && !(f_xfer || f_apm_on || f_apm_of || f_pl1_on
                  || f_pl1_of || f_cur || f_keep || f_rev || f_nop);
    wire xf_bad  = f_xfer && !xd.ok;
    wire apm_bad = f_apm_on && !apm_ok;

    // Set-max subcommands
    wire s_addr  = is_sm && (ft == SM_ADDR);
    wire s_pw    = is_sm && (ft == SM_SET_PW);
    wire s_lock  = is_sm && (ft == SM_LOCK);
    wire s_unlk  = is_sm && (ft == SM_UNLOCK);
    wire s_frz   = is_sm && (ft == SM_FREEZE);
    wire sm_rsvd = is_sm && (ft > SM_FREEZE);

    // New maximum from the address registers
    wire [27:0] new_max = {cmd_r.dev_head[3:0], cmd_r.cyl_high,
                           cmd_r.cyl_low, cmd_r.sect_num};
    wire nv_req = cmd_r.sect_cnt[NV_BIT];
    wire lba_ok = cmd_r.dev_head[LBA_BIT];

    // Address set needs ready, a preceding native read, LBA form
    wire addr_bad = s_addr && (!dev_ready || !rnm_prev_r
                  || !lba_ok || lock_r || frz_r
                  || (new_max > NATIVE_MAX)
                  || (nv_req && nv_used_r));
    // Once frozen every security subcommand is refused
    wire sec_bad  = (s_pw || s_lock || s_unlk || s_frz) && frz_r;

    wire abort_now = sf_bad || xf_bad || apm_bad || sm_rsvd
                   || addr_bad || sec_bad;
    wire addr_go   = s_addr && !addr_bad;

    ////////////////////////////////////////////////////////////////
    // Sequencing
    ////////////////////////////////////////////////////////////////

    // One command in flight; the next waits for the answer
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:
            begin
                if (cmd_valid)
                    st_nxt = ST_EXEC;
            end
            ST_EXEC:
                st_nxt = ST_IDLE;
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    // Resets return to idle and mask done; a soft reset still lets set-max and lock effects land
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            st_r <= ST_IDLE;
        else if (hw_reset || soft_reset)
            st_r <= ST_IDLE;
        else
            st_r <= st_nxt;
    end

    // Task file captured on acceptance
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            cmd_r <= '0;
        else if (cmd_valid && cmd_ready)
            cmd_r <= cmd_in;
    end

    ////////////////////////////////////////////////////////////////
    // Transfer mode
    ////////////////////////////////////////////////////////////////

    // Hardware and reverting soft resets both land on defaults
    wire restore = hw_reset || (soft_reset && revert_r);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            xf_r  <= '0;
            noi_r <= 1'b0;
        end
        else if (restore)
        begin
            xf_r  <= '0;
            noi_r <= 1'b0;
        end
        else if (f_xfer && xd.ok)
        begin
            if (xd.pio_def || xd.no_iordy)
            begin
                xf_r.pio_mode <= PIO_MODE_RST;
                noi_r         <= xd.no_iordy;
            end
            else if (xd.pio_fc)
            begin
                xf_r.pio_mode <= xd.mode;
                noi_r         <= 1'b0;
            end
            else if (xd.mdma)
            begin
                xf_r.mdma_en   <= 1'b1;
                xf_r.mdma_mode <= xd.mode;
                xf_r.udma_en   <= 1'b0;
            end
            else
            begin
                xf_r.udma_en   <= 1'b1;
                xf_r.udma_mode <= xd.mode;
                xf_r.mdma_en   <= 1'b0;
            end
        end
        // A card-bus mode switch withdraws Multiword DMA
        else if (pc_card_mode && xf_r.mdma_en)
            xf_r.mdma_en <= 1'b0;
    end

    // IORDY is forced on at the faster PIO modes
    wire iordy_live = (xf_r.pio_mode >= PIO_IORDY_MIN) || !noi_r;

    ////////////////////////////////////////////////////////////////
    // Power settings
    ////////////////////////////////////////////////////////////////

    // The level is stored, reported and gates standby_permit; it shapes no timing
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            apm_en_r  <= APM_EN_RST;
            apm_lvl_r <= APM_LEVEL_RST;
            pl1_r     <= PL1_EN_RST;
            cur_r     <= CUR_MAX;
        end
        else if (restore)
        begin
            apm_en_r  <= APM_EN_RST;
            apm_lvl_r <= APM_LEVEL_RST;
            pl1_r     <= PL1_EN_RST;
            cur_r     <= CUR_MAX;
        end
        else
        begin
            if (f_apm_on && apm_ok)
            begin
                apm_en_r  <= 1'b1;
                apm_lvl_r <= cmd_r.sect_cnt;
            end
            else if (f_apm_of)
                apm_en_r  <= 1'b0;
            if (f_pl1_on)
                pl1_r <= 1'b1;
            else if (f_pl1_of)
                pl1_r <= 1'b0;
            if (f_cur)
                cur_r <= clamp_cur(cmd_r.sect_cnt);
        end
    end

    // Revert choice survives the soft reset it governs
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            revert_r <= POR_REVERT_RST;
        else if (hw_reset)
            revert_r <= POR_REVERT_RST;
        else if (f_keep)
            revert_r <= 1'b0;
        else if (f_rev)
            revert_r <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // Max address
    ////////////////////////////////////////////////////////////////

    // Power-on brings back the native size; a hardware reset
    // brings back the last non-volatile setting
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            max_r     <= NATIVE_MAX;
            nv_max_r  <= NATIVE_MAX;
            nv_used_r <= 1'b0;
        end
        else if (hw_reset)
        begin
            max_r     <= nv_max_r;
            nv_used_r <= 1'b0;
        end
        else if (addr_go)
        begin
            max_r <= new_max;
            if (nv_req)
            begin
                nv_max_r  <= new_max;
                nv_used_r <= 1'b1;
            end
        end
    end

    // Native read must be the command just before the set
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rnm_prev_r <= 1'b0;
        else if (hw_reset || soft_reset)
            rnm_prev_r <= 1'b0;
        else if (exec)
            rnm_prev_r <= is_rnm && dev_ready;
    end

    // Lock, freeze and password state; freeze lasts until a hardware reset
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            lock_r <= 1'b0;
            frz_r  <= 1'b0;
            pw_r   <= 1'b0;
        end
        else if (hw_reset)
        begin
            lock_r <= 1'b0;
            frz_r  <= 1'b0;
        end
        else if (!sec_bad)
        begin
            if (s_pw)
                pw_r <= 1'b1;
            if (s_lock)
                lock_r <= 1'b1;
            else if (s_unlk)
                lock_r <= 1'b0;
            if (s_frz)
                frz_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Answer
    ////////////////////////////////////////////////////////////////

    // Completion registers, one cycle after execution
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            done_r  <= 1'b0;
            abort_r <= 1'b0;
            res_r   <= '0;
        end
        else
        begin
            done_r  <= exec && !hw_reset && !soft_reset;
            abort_r <= exec && abort_now && !hw_reset && !soft_reset;
            if (exec)
            begin
                res_r <= cmd_r;
                if (f_cur)
                begin
                    res_r.cyl_low  <= CUR_MIN;
                    res_r.cyl_high <= CUR_MAX;
                end
                else if (is_rnm)
                begin
                    res_r.dev_head[3:0] <= NATIVE_MAX[27:24];
                    res_r.cyl_high      <= NATIVE_MAX[23:16];
                    res_r.cyl_low       <= NATIVE_MAX[15:8];
                    res_r.sect_num      <= NATIVE_MAX[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////

    assign cmd_ready        = (st_r == ST_IDLE);
    assign done             = done_r;
    assign aborted          = abort_r;
    assign result           = res_r;
    assign xfer_cfg.pio_mode  = xf_r.pio_mode;
    assign xfer_cfg.iordy_en  = iordy_live;
    assign xfer_cfg.mdma_en   = xf_r.mdma_en;
    assign xfer_cfg.mdma_mode = xf_r.mdma_mode;
    assign xfer_cfg.udma_en   = xf_r.udma_en;
    assign xfer_cfg.udma_mode = xf_r.udma_mode;
    assign apm_en           = apm_en_r;
    assign apm_level        = apm_lvl_r;
    // Standby only while management is on and below the band
    assign standby_permit   = apm_en_r && !cur_nostby;
    assign pl1_en           = pl1_r;
    assign cur_limit        = cur_r;
    assign por_revert       = revert_r;
    assign max_lba          = max_r;
    assign max_locked       = lock_r;
    assign max_frozen       = frz_r;
    assign pw_set           = pw_r;

endmodule // set_features_and_max_address
`default_nettype wire

// ---- hw/feat_pkg.sv ----
`default_nettype none
package feat_pkg;

    // Command opcodes
    localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
    localparam logic [7:0] CMD_READ_NATIVE  = 8'hF8;
    localparam logic [7:0] CMD_SET_MAX      = 8'hF9;

    // Set Features subcommands
    localparam logic [7:0] FEAT_XFER_MODE  = 8'h03;
    localparam logic [7:0] FEAT_APM_ON     = 8'h05;
    localparam logic [7:0] FEAT_APM_OFF    = 8'h85;
    localparam logic [7:0] FEAT_PL1_ON     = 8'h0A;
    localparam logic [7:0] FEAT_PL1_OFF    = 8'h8A;
    localparam logic [7:0] FEAT_LOOKAHD_A  = 8'h55;
    localparam logic [7:0] FEAT_LOOKAHD_B  = 8'hAA;
    localparam logic [7:0] FEAT_LONG4      = 8'hBB;
    localparam logic [7:0] FEAT_CUR_LIMIT  = 8'h9A;
    localparam logic [7:0] FEAT_POR_KEEP   = 8'h66;
    localparam logic [7:0] FEAT_POR_REVERT = 8'hCC;
    localparam logic [7:0] FEAT_NOP_A      = 8'h69;
    localparam logic [7:0] FEAT_NOP_B      = 8'h96;
    localparam logic [7:0] FEAT_NOP_C      = 8'h97;

    // Transfer-mode sector-count layout
    localparam int         XT_TYPE_LSB     = 3;
    localparam logic [4:0] XT_PIO_DEF      = 5'h00;
    localparam logic [4:0] XT_PIO_FC       = 5'h01;
    localparam logic [4:0] XT_MDMA         = 5'h04;
    localparam logic [4:0] XT_UDMA         = 5'h08;
    localparam logic [2:0] XM_PIO_DEF      = 3'h0;
    localparam logic [2:0] XM_NO_IORDY     = 3'h1;
    localparam logic [2:0] PIO_IORDY_MIN   = 3'h3;

    // Power-management levels
    localparam logic [7:0] APM_RSVD_LO     = 8'h00;
    localparam logic [7:0] APM_RSVD_HI     = 8'hFF;
    localparam logic [7:0] APM_NO_STBY_MIN = 8'h80;

    // Set-max subcommands and field positions
    localparam logic [7:0] SM_ADDR         = 8'h00;
    localparam logic [7:0] SM_SET_PW       = 8'h01;
    localparam logic [7:0] SM_LOCK         = 8'h02;
    localparam logic [7:0] SM_UNLOCK       = 8'h03;
    localparam logic [7:0] SM_FREEZE       = 8'h04;
    localparam int         NV_BIT          = 0;
    localparam int         LBA_BIT         = 6;

    // Reset values
    localparam logic [2:0] PIO_MODE_RST    = 3'h0;
    localparam logic [7:0] APM_LEVEL_RST   = 8'hFE;
    localparam logic       APM_EN_RST      = 1'b0;
    localparam logic       PL1_EN_RST      = 1'b0;
    localparam logic       POR_REVERT_RST  = 1'b1;

    // Task-file image of one command
    typedef struct packed {
        logic [7:0] command;
        logic [7:0] features;
        logic [7:0] sect_cnt;
        logic [7:0] sect_num;
        logic [7:0] cyl_low;
        logic [7:0] cyl_high;
        logic [7:0] dev_head;
    } cmd_t;

    // Decoded transfer-mode request
    typedef struct packed {
        logic       ok;
        logic       pio_def;
        logic       no_iordy;
        logic       pio_fc;
        logic       mdma;
        logic       udma;
        logic [2:0] mode;
    } xfer_dec_t;

    // Live transfer configuration
    typedef struct packed {
        logic [2:0] pio_mode;
        logic       iordy_en;
        logic       mdma_en;
        logic [2:0] mdma_mode;
        logic       udma_en;
        logic [2:0] udma_mode;
    } xfer_cfg_t;

endpackage
`default_nettype wire

// ---- hw/xfer_mode_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module xfer_mode_decode
    import feat_pkg::*;
#(
    parameter logic [2:0] PIO_MAX   = 3'h4,
    parameter logic [2:0] MDMA_MAX  = 3'h2,
    parameter logic [2:0] UDMA_MAX  = 3'h2,
    parameter logic       NO_IORDY_OK = 1'b1
)(
    input  wire logic [7:0] sect_cnt,
    input  wire logic       pc_card_mode,
    output xfer_dec_t       dec
);
    // Type and mode fields
    wire [4:0] xtype = sect_cnt[7:XT_TYPE_LSB];
    wire [2:0] xmode = sect_cnt[2:0];

    // Default PIO: all-zero, or IORDY off when supported
    wire is_def   = (xtype == XT_PIO_DEF) && (xmode == XM_PIO_DEF);
    wire is_noi   = (xtype == XT_PIO_DEF) && (xmode == XM_NO_IORDY) && NO_IORDY_OK;
    // Every mode up to the advertised top is accepted
    wire is_fc    = (xtype == XT_PIO_FC) && (xmode <= PIO_MAX);
    // Multiword DMA is never allowed in the card-bus modes
    wire is_mdma  = (xtype == XT_MDMA) && (xmode <= MDMA_MAX) && !pc_card_mode;
    wire is_udma  = (xtype == XT_UDMA) && (xmode <= UDMA_MAX);

    assign dec.pio_def  = is_def;
    assign dec.no_iordy = is_noi;
    assign dec.pio_fc   = is_fc;
    assign dec.mdma     = is_mdma;
    assign dec.udma     = is_udma;
    assign dec.mode     = xmode;
    assign dec.ok       = is_def | is_noi | is_fc | is_mdma | is_udma;
endmodule // xfer_mode_decode
`default_nettype wire

// ---- hw/apm_level_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module apm_level_decode
    import feat_pkg::*;
(
    input  wire logic [7:0] level,
    output logic            valid,
    output logic            no_standby
);
    // Both ends of the scale are reserved
    assign valid      = (level != APM_RSVD_LO) && (level != APM_RSVD_HI);
    // Upper half of the scale forbids the deep power-saving state
    assign no_standby = (level >= APM_NO_STBY_MIN);
endmodule // apm_level_decode
`default_nettype wire

// ---- bench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model
    import feat_pkg::*;
(
    input  wire logic mclk,
    input  wire logic cmd_ready,
    output var logic  cmd_valid,
    output var cmd_t  cmd_in
);
    initial cmd_valid = 1'b0;
    initial cmd_in = '0;
    // Hold the image until taken, then scramble it so stale bytes never look valid
    task automatic cmd(input logic [7:0] c, f, s, input logic [27:0] a, input logic lba);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_in <= {c, f, s, a[7:0], a[15:8], a[23:16], 1'b1, lba, 2'b10, a[27:24]};
        @(posedge mclk);
        while (cmd_ready !== 1'b1)
            @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_in <= ~cmd_in;
        repeat (1) @(posedge mclk);
        #1;
    endtask
endmodule // host_model
`default_nettype wire

// ---- bench/feat_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module feat_sva
    import feat_pkg::*;
#(
    parameter logic [7:0] CUR_MIN = 8'h01,
    parameter logic [7:0] CUR_MAX = 8'h40
)(
    input wire logic mclk, resetn, pc_card_mode, cmd_valid, cmd_ready, done, aborted, standby_permit,
    input wire cmd_t cmd_in, result,
    input wire xfer_cfg_t xfer_cfg,
    input wire logic [7:0] apm_level,
    input wire logic [27:0] max_lba
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_lat; cmd_valid && cmd_ready |=> !cmd_ready ##1 done && cmd_ready; endproperty
    a_lat: assert property (p_lat) else $error("bad latency");
    property p_abt; aborted |-> done; endproperty
    a_abt: assert property (p_abt) else $error("stray abort");
    property p_io; xfer_cfg.pio_mode >= PIO_IORDY_MIN |-> xfer_cfg.iordy_en; endproperty
    a_io: assert property (p_io) else $error("flow control off");
    property p_one; !(xfer_cfg.mdma_en && xfer_cfg.udma_en); endproperty
    a_one: assert property (p_one) else $error("two dma families");
    property p_pc; pc_card_mode && $past(pc_card_mode) |-> !xfer_cfg.mdma_en; endproperty
    a_pc: assert property (p_pc) else $error("mdma in card mode");
    property p_sb; apm_level >= APM_NO_STBY_MIN |-> !standby_permit; endproperty
    a_sb: assert property (p_sb) else $error("standby at high level");
    property p_cur; cmd_valid && cmd_ready && cmd_in.command == CMD_SET_FEATURES && cmd_in.features
        == FEAT_CUR_LIMIT ##2 done && !aborted |-> result.cyl_low == CUR_MIN && result.cyl_high == CUR_MAX; endproperty
    a_cur: assert property (p_cur) else $error("bad current range");
    property p_keep; done && aborted |-> $stable(max_lba) && $stable(xfer_cfg); endproperty
    a_keep: assert property (p_keep) else $error("abort changed state");
    c_abt: cover property (done && aborted);
    c_ok: cover property (done && !aborted);
    c_pc: cover property (pc_card_mode && done);
endmodule // feat_sva
bind set_features_and_max_address feat_sva #(.CUR_MIN(CUR_MIN), .CUR_MAX(CUR_MAX)) i_sva (.*);
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import feat_pkg::*;
;
    logic mclk = 1'b0, resetn = 1'b0, hw_reset = 1'b0, soft_reset = 1'b0, dev_ready = 1'b1, pc_card_mode = 1'b0;
    logic cmd_valid, cmd_ready, done, aborted, apm_en, standby_permit, pl1_en, por_revert, max_locked, max_frozen, pw_set;
    logic [7:0] apm_level, cur_limit;
    logic [27:0] max_lba;
    cmd_t cmd_in, result;
    xfer_cfg_t xfer_cfg;
    int n_errors = 0, samples_checked = 0;
    // Rows: code, sector count, expected abort in the low bit
    logic [19:0] rows [24] = '{20'h03000, 20'h03010, 20'h030C0, 20'h030D1, 20'h03080, 20'h03200, 20'h03231,
        20'h03420, 20'h03431, 20'h03101, 20'h05FE0, 20'h05010, 20'h05001, 20'h05FF1, 20'h85000, 20'h8A000,
        20'h55000, 20'hAA000, 20'hBB000, 20'h69000, 20'h96000, 20'h97000, 20'h01001, 20'h20001};
    set_features_and_max_address i_dut (.*);
    host_model i_host (.*);
    always #12.5 mclk = ~mclk;
    task chk(input logic [27:0] g, e);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task close_out;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task sf(input logic [7:0] f, s, input logic ab);
        i_host.cmd(CMD_SET_FEATURES, f, s, 28'h0, 1'b1);
        chk({done, aborted}, {1'b1, ab});
    endtask
    task sm(input logic [7:0] f, s, input logic [27:0] a, input logic lba, ab);
        i_host.cmd(CMD_SET_MAX, f, s, a, lba);
        chk({done, aborted}, {1'b1, ab});
    endtask
    task rn;
        i_host.cmd(CMD_READ_NATIVE, 8'h00, 8'h00, 28'h0, 1'b1);
        chk({result.dev_head[3:0], result.cyl_high, result.cyl_low, result.sect_num}, 28'hFFFFFFF);
    endtask
    // One-cycle hardware or soft reset pulse, never with a command in flight
    task rst(input logic h);
        @(posedge mclk) {hw_reset, soft_reset} <= {h, !h};
        @(posedge mclk) {hw_reset, soft_reset} <= 2'h0;
        #1;
    endtask
    initial
    begin
        #50us;
        n_errors++;
        close_out;
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        chk({xfer_cfg.pio_mode, apm_en, apm_level, pl1_en, por_revert, cur_limit}, 22'h03F940);
        foreach (rows[i]) sf(rows[i][19:12], rows[i][11:4], rows[i][0]);
        sf(8'h03, 8'h01, 1'b0);
        chk(xfer_cfg.iordy_en, 1'b0);
        sf(8'h03, 8'h0C, 1'b0);
        chk({xfer_cfg.pio_mode, xfer_cfg.iordy_en}, 4'h9);
        sf(8'h03, 8'h22, 1'b0);
        sf(8'h03, 8'h42, 1'b0);
        chk({xfer_cfg.mdma_en, xfer_cfg.udma_en, xfer_cfg.udma_mode}, 5'h0A);
        sf(8'h03, 8'h21, 1'b0);
        @(posedge mclk) pc_card_mode <= 1'b1;
        sf(8'h03, 8'h20, 1'b1);
        chk(xfer_cfg.mdma_en, 1'b0);
        @(posedge mclk) pc_card_mode <= 1'b0;
        sf(8'h05, 8'h80, 1'b0);
        chk({apm_en, apm_level, standby_permit}, 10'h300);
        sf(8'h05, 8'h7F, 1'b0);
        chk(standby_permit, 1'b1);
        sf(8'h85, 8'h00, 1'b0);
        sf(8'h0A, 8'h00, 1'b0);
        chk({apm_en, pl1_en}, 2'h1);
        sf(8'h9A, 8'hFF, 1'b0);
        chk({result.cyl_low, result.cyl_high, cur_limit}, 24'h014040);
        sf(8'h9A, 8'h00, 1'b0);
        sf(8'h66, 8'h00, 1'b0);
        rst(1'b0);
        chk({xfer_cfg.pio_mode, cur_limit}, 11'h401);
        sf(8'hCC, 8'h00, 1'b0);
        rst(1'b0);
        chk({xfer_cfg.pio_mode, cur_limit, pl1_en}, 12'h080);
        sm(8'h00, 8'h01, 28'h0123456, 1'b1, 1'b1);
        rn;
        @(posedge mclk) dev_ready <= 1'b0;
        sm(8'h00, 8'h01, 28'h0123456, 1'b1, 1'b1);
        @(posedge mclk) dev_ready <= 1'b1;
        rn;
        sm(8'h00, 8'h01, 28'h0123456, 1'b0, 1'b1);
        rn;
        sm(8'h00, 8'h01, 28'h0123456, 1'b1, 1'b0);
        rn;
        sm(8'h00, 8'h01, 28'h0000777, 1'b1, 1'b1);
        rn;
        sm(8'h00, 8'h00, 28'h0000100, 1'b1, 1'b0);
        rst(1'b1);
        chk(max_lba, 28'h0123456);
        sm(8'h05, 8'h00, 28'h0, 1'b1, 1'b1);
        sm(8'h01, 8'h00, 28'h0, 1'b1, 1'b0);
        sm(8'h02, 8'h00, 28'h0, 1'b1, 1'b0);
        chk({pw_set, max_locked}, 2'h3);
        sm(8'h03, 8'h00, 28'h0, 1'b1, 1'b0);
        sm(8'h04, 8'h00, 28'h0, 1'b1, 1'b0);
        sm(8'h02, 8'h00, 28'h0, 1'b1, 1'b1);
        chk({pw_set, max_locked, max_frozen}, 3'h5);
        close_out;
    end
endmodule // tb_top
`default_nettype wire
